// ===== verilog/interrupt_enable_flag_logic.sv
// Interrupt enable and flag logic with an Avalon-MM register slave.
// Assumes tick, wakeup and peripheral flag inputs come from logic on clock;
// port pins and the external interrupt pin are asynchronous and synchronised.
`include "irq_enable_map.svh"

module interrupt_enable_flag_logic (
    input  wire logic                   clock,
    input  wire logic                   rst_n,
    input  wire logic [`IRQ_ADDR_W-1:0] avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    input  wire logic [3:0]             avs_byteenable,
    output logic      [31:0]            avs_readdata,
    output logic                        avs_waitrequest,
    input  wire logic                   tickRollover,
    input  wire logic                   externalIrqPin,
    input  wire logic                   extEdgeRising,
    input  wire logic [7:0]             portPinsA,
    input  wire logic [7:0]             portPinsB,
    input  wire logic                   lowPowerWakeup,
    input  wire logic [7:0]             periphFlags,
    output logic                        coreIrqReq,
    output logic                        irqOut
);

    // Address match of a word-aligned register
    function automatic logic regHit(
        input logic [`IRQ_ADDR_W-1:0] addr,
        input logic [`IRQ_ADDR_W-1:0] ofs
    );
        regHit = (addr[`IRQ_ADDR_W-1:2] == ofs[`IRQ_ADDR_W-1:2]);
    endfunction : regHit

    // Any enabled bit that differs from its previous sample
    function automatic logic pinsChanged(
        input logic [7:0] now,
        input logic [7:0] prev,
        input logic [7:0] enables
    );
        pinsChanged = |((now ^ prev) & enables);
    endfunction : pinsChanged

    irq_enable_pkg::bus_state_t busState_r;
    irq_enable_pkg::bus_state_t busState_nxt;

    irq_enable_pkg::byte_t      control_r;
    irq_enable_pkg::byte_t      control_nxt;
    irq_enable_pkg::byte_t      periphEn1_r;
    irq_enable_pkg::byte_t      periphEn1_nxt;
    irq_enable_pkg::byte_t      pinEnA_r;
    irq_enable_pkg::byte_t      pinEnA_nxt;
    irq_enable_pkg::byte_t      pinEnB_r;
    irq_enable_pkg::byte_t      pinEnB_nxt;

    logic [`IRQ_EVT_W-1:0]      evtStatus_r;
    logic [`IRQ_EVT_W-1:0]      evtStatus_nxt;
    logic [`IRQ_EVT_W-1:0]      evtMask_r;
    logic [`IRQ_EVT_W-1:0]      evtMask_nxt;
    logic [`IRQ_EVT_W-1:0]      evtSet;

    logic [31:0]                readData_r;
    logic [31:0]                readData_nxt;
    logic                       waitReq_r;
    logic                       coreIrqReq_r;
    logic                       coreIrqReq_nxt;
    logic                       irqOut_r;
    logic                       irqOut_nxt;

    logic                       extMeta_r;
    logic                       extSync_r;
    logic                       extPrev_r;
    logic [7:0]                 pinsAMeta_r;
    logic [7:0]                 pinsASync_r;
    logic [7:0]                 pinsAPrev_r;
    logic [7:0]                 pinsBMeta_r;
    logic [7:0]                 pinsBSync_r;
    logic [7:0]                 pinsBPrev_r;
    logic                       prevValid_r;
    logic [1:0]                 fill_r;

    wire                        request;
    wire                        accept;
    wire                        wrAccept;
    wire                        lane0;
    wire                        hitControl;
    wire                        hitPeriphEn1;
    wire                        hitPinEnA;
    wire                        hitPinEnB;
    wire                        hitStatus;
    wire                        hitMask;
    wire [7:0]                  wrByte;
    wire                        wrControl;
    wire                        wrPeriphEn1;
    wire                        wrPinEnA;
    wire                        wrPinEnB;
    wire                        wrStatus;
    wire                        wrMask;

    wire                        tickSet;
    wire                        extSet;
    wire                        portSet;
    wire                        extEdge;
    wire                        pinChange;
    wire                        extRise;
    wire                        extFall;
    wire                        pinChangeA;
    wire                        pinChangeB;

    wire                        globalEn;
    wire                        groupEn;
    wire                        tickPend;
    wire                        extPend;
    wire                        portPend;
    wire                        corePend;
    wire                        periphPend;
    wire [7:0]                  flagSet;
    wire [7:0]                  ctrlWrite;
    wire [`IRQ_EVT_W-1:0]       statusKept;

    // Bus decode
    assign request      = avs_read | avs_write;
    assign accept       = request & ~waitReq_r;
    assign wrAccept     = avs_write & accept & lane0;
    assign lane0        = avs_byteenable[0];
    assign wrByte       = avs_writedata[7:0];
    assign hitControl   = regHit(avs_address, `IRQ_OFS_CONTROL);
    assign hitPeriphEn1 = regHit(avs_address, `IRQ_OFS_PERIPH_EN1);
    assign hitPinEnA    = regHit(avs_address, `IRQ_OFS_PIN_EN_A);
    assign hitPinEnB    = regHit(avs_address, `IRQ_OFS_PIN_EN_B);
    assign hitStatus    = regHit(avs_address, `IRQ_OFS_EVT_STATUS);
    assign hitMask      = regHit(avs_address, `IRQ_OFS_EVT_MASK);

    // Accepted writes, one strobe per register
    assign wrControl    = wrAccept & hitControl;
    assign wrPeriphEn1  = wrAccept & hitPeriphEn1;
    assign wrPinEnA     = wrAccept & hitPinEnA;
    assign wrPinEnB     = wrAccept & hitPinEnB;
    assign wrStatus     = wrAccept & hitStatus;
    assign wrMask       = wrAccept & hitMask;

    // Source event detection
    assign tickSet    = tickRollover;
    assign extRise    = extSync_r & ~extPrev_r;
    assign extFall    = ~extSync_r & extPrev_r;
    assign extEdge    = extEdgeRising ? extRise : extFall;
    assign extSet     = extEdge & prevValid_r;
    assign pinChangeA = pinsChanged(pinsASync_r, pinsAPrev_r, pinEnA_r);
    assign pinChangeB = pinsChanged(pinsBSync_r, pinsBPrev_r, pinEnB_r);
    assign pinChange  = prevValid_r & (pinChangeA | pinChangeB);
    assign portSet    = pinChange | lowPowerWakeup;

    // Flags set whatever the control enables hold; pin changes need their pin enables
    assign flagSet = {5'h00, tickSet, extSet, portSet};

    // Control register write; a set arriving with a clear wins
    assign ctrlWrite = wrControl ? wrByte : control_r;

    always_comb begin
        control_nxt = ctrlWrite | flagSet;
    end

    // Enable registers
    assign periphEn1_nxt = wrPeriphEn1
                         ? (wrByte & `IRQ_PE1_WMASK)
                         : periphEn1_r;
    assign pinEnA_nxt    = wrPinEnA ? wrByte : pinEnA_r;
    assign pinEnB_nxt    = wrPinEnB ? wrByte : pinEnB_r;
    assign evtMask_nxt   = wrMask
                         ? wrByte[`IRQ_EVT_W-1:0]
                         : evtMask_r;

    // Request to the core
    assign globalEn   = control_r[`IRQ_BIT_GLOBAL_EN];
    assign groupEn    = control_r[`IRQ_BIT_GROUP_EN];
    assign tickPend   = control_r[`IRQ_BIT_TICK_EN]
                      & control_r[`IRQ_BIT_TICK_FLAG];
    assign extPend    = control_r[`IRQ_BIT_EXT_EN]
                      & control_r[`IRQ_BIT_EXT_FLAG];
    assign portPend   = control_r[`IRQ_BIT_PORT_EN]
                      & control_r[`IRQ_BIT_PORT_FLAG];
    assign corePend   = tickPend | extPend | portPend;
    // Bits 6..0: conversion, rx, tx, sync serial, capture, match, timer two
    assign periphPend = groupEn & |(periphEn1_r & periphFlags);

    assign coreIrqReq_nxt = globalEn & (corePend | periphPend);

    // Sticky event status, write one to clear, set wins
    assign evtSet[`IRQ_EVT_TICK] = tickSet;
    assign evtSet[`IRQ_EVT_EXT]  = extSet;
    assign evtSet[`IRQ_EVT_PORT] = portSet;
    assign evtSet[`IRQ_EVT_REQ]  = coreIrqReq_nxt & ~coreIrqReq_r;

    assign statusKept    = wrStatus ? (evtStatus_r & ~wrByte[`IRQ_EVT_W-1:0])
                                    : evtStatus_r;
    assign evtStatus_nxt = statusKept | evtSet;

    // Next values, so irqOut rises with its status bit
    assign irqOut_nxt = |(evtStatus_nxt & evtMask_nxt);

    // Read mux
    // Data follow the address every cycle; valid while waitrequest is low
    always_comb begin
        readData_nxt = 32'h0000_0000;
        if (hitControl) begin
            readData_nxt[7:0] = control_r;
        end else if (hitPeriphEn1) begin
            readData_nxt[7:0] = periphEn1_r;
        end else if (hitPinEnA) begin
            readData_nxt[7:0] = pinEnA_r;
        end else if (hitPinEnB) begin
            readData_nxt[7:0] = pinEnB_r;
        end else if (hitStatus) begin
            readData_nxt[`IRQ_EVT_W-1:0] = evtStatus_r;
        end else if (hitMask) begin
            readData_nxt[`IRQ_EVT_W-1:0] = evtMask_r;
        end
    end

    // Bus sequencing: one wait cycle, then answer
    always_comb begin
        busState_nxt = busState_r;
        unique case (busState_r)
            irq_enable_pkg::BUS_WAIT: begin
                if (request) begin
                    busState_nxt = irq_enable_pkg::BUS_ANSWER;
                end
            end
            irq_enable_pkg::BUS_ANSWER: begin
                busState_nxt = irq_enable_pkg::BUS_WAIT;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            busState_r <= irq_enable_pkg::BUS_WAIT;
            waitReq_r  <= 1'b1;
            readData_r <= 32'h0000_0000;
        end else begin
            busState_r <= busState_nxt;
            waitReq_r  <= (busState_nxt != irq_enable_pkg::BUS_ANSWER);
            readData_r <= readData_nxt;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            control_r   <= `IRQ_RST_CONTROL;
            periphEn1_r <= `IRQ_RST_PERIPH_EN1;
            pinEnA_r    <= `IRQ_RST_PIN_EN;
            pinEnB_r    <= `IRQ_RST_PIN_EN;
        end else begin
            control_r   <= control_nxt;
            periphEn1_r <= periphEn1_nxt;
            pinEnA_r    <= pinEnA_nxt;
            pinEnB_r    <= pinEnB_nxt;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            evtStatus_r  <= `IRQ_RST_EVT;
            evtMask_r    <= `IRQ_RST_EVT;
            coreIrqReq_r <= 1'b0;
            irqOut_r     <= 1'b0;
        end else begin
            evtStatus_r  <= evtStatus_nxt;
            evtMask_r    <= evtMask_nxt;
            coreIrqReq_r <= coreIrqReq_nxt;
            irqOut_r     <= irqOut_nxt;
        end
    end

    // External pin synchroniser; only the second flop feeds logic
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            extMeta_r <= 1'b0;
            extSync_r <= 1'b0;
        end else begin
            extMeta_r <= externalIrqPin;
            extSync_r <= extMeta_r;
        end
    end

    // Port pin synchronisers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pinsAMeta_r <= 8'h00;
            pinsASync_r <= 8'h00;
            pinsBMeta_r <= 8'h00;
            pinsBSync_r <= 8'h00;
        end else begin
            pinsAMeta_r <= portPinsA;
            pinsASync_r <= pinsAMeta_r;
            pinsBMeta_r <= portPinsB;
            pinsBSync_r <= pinsBMeta_r;
        end
    end

    // Previous samples; blind until both compared samples come from the pins
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            extPrev_r   <= 1'b0;
            pinsAPrev_r <= 8'h00;
            pinsBPrev_r <= 8'h00;
            prevValid_r <= 1'b0;
            fill_r      <= 2'b00;
        end else begin
            extPrev_r   <= extSync_r;
            pinsAPrev_r <= pinsASync_r;
            pinsBPrev_r <= pinsBSync_r;
            prevValid_r <= fill_r[1];
            fill_r      <= {fill_r[0], 1'b1};
        end
    end

    // The tick counter itself lives outside; its reload is software's job
    // before the overflow flag is cleared.

    assign avs_readdata    = readData_r;
    assign avs_waitrequest = waitReq_r;
    assign coreIrqReq      = coreIrqReq_r;
    assign irqOut          = irqOut_r;

endmodule : interrupt_enable_flag_logic

// ===== verilog/irq_enable_map.svh
// Register offsets, field positions and reset values of the interrupt block.
// Assumes a byte-addressed Avalon-MM slave with 32-bit data words.
`ifndef IRQ_ENABLE_MAP_SVH
`define IRQ_ENABLE_MAP_SVH

`define IRQ_ADDR_W          5
`define IRQ_OFS_CONTROL     5'h00
`define IRQ_OFS_PERIPH_EN1  5'h04
`define IRQ_OFS_PIN_EN_A    5'h08
`define IRQ_OFS_PIN_EN_B    5'h0c
`define IRQ_OFS_EVT_STATUS  5'h10
`define IRQ_OFS_EVT_MASK    5'h14

`define IRQ_BIT_GLOBAL_EN   7
`define IRQ_BIT_GROUP_EN    6
`define IRQ_BIT_TICK_EN     5
`define IRQ_BIT_EXT_EN      4
`define IRQ_BIT_PORT_EN     3
`define IRQ_BIT_TICK_FLAG   2
`define IRQ_BIT_EXT_FLAG    1
`define IRQ_BIT_PORT_FLAG   0

`define IRQ_PE1_WMASK       8'h7f

`define IRQ_EVT_TICK        0
`define IRQ_EVT_EXT         1
`define IRQ_EVT_PORT        2
`define IRQ_EVT_REQ         3
`define IRQ_EVT_W           4

`define IRQ_RST_CONTROL     8'h00
`define IRQ_RST_PERIPH_EN1  8'h00
`define IRQ_RST_PIN_EN      8'h00
`define IRQ_RST_EVT         4'h0

`endif

// ===== verilog/irq_enable_pkg.sv
// Types shared by the interrupt enable and flag block.
// Assumes the constants of irq_enable_map.svh for widths and offsets.
package irq_enable_pkg;

    typedef logic [7:0] byte_t;

    typedef enum logic {
        BUS_WAIT   = 1'b0,
        BUS_ANSWER = 1'b1
    } bus_state_t;

endpackage : irq_enable_pkg

// ===== verification/interrupt_enable_flag_logic_checker.sv
// Port-level checks of the interrupt enable and flag block.
// Assumes enables change only by bus writes at the waitrequest-low edge.
`include "irq_enable_map.svh"
module interrupt_enable_flag_logic_checker (
    input wire logic                   clock,
    input wire logic                   rst_n,
    input wire logic [`IRQ_ADDR_W-1:0] avs_address,
    input wire logic                   avs_read,
    input wire logic                   avs_write,
    input wire logic [31:0]            avs_writedata,
    input wire logic [3:0]             avs_byteenable,
    input wire logic [31:0]            avs_readdata,
    input wire logic                   avs_waitrequest,
    input wire logic                   tickRollover,
    input wire logic                   externalIrqPin,
    input wire logic                   extEdgeRising,
    input wire logic [7:0]             portPinsA,
    input wire logic [7:0]             portPinsB,
    input wire logic                   lowPowerWakeup,
    input wire logic [7:0]             periphFlags,
    input wire logic                   coreIrqReq,
    input wire logic                   irqOut
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       done, wrDone;
    logic [4:0] wordAddr;
    logic [7:0] ctlS_r, pe1S_r, maskS_r;
    assign done = !avs_waitrequest;
    assign wrDone = avs_write && done && avs_byteenable[0];
    assign wordAddr = {avs_address[4:2], 2'b00};
    // Shadow of software-owned enables
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctlS_r  <= 8'h00;
            pe1S_r  <= 8'h00;
            maskS_r <= 8'h00;
        end else if (wrDone) begin
            if (wordAddr == `IRQ_OFS_CONTROL) ctlS_r <= avs_writedata[7:0];
            if (wordAddr == `IRQ_OFS_PERIPH_EN1) pe1S_r <= avs_writedata[7:0] & `IRQ_PE1_WMASK;
            if (wordAddr == `IRQ_OFS_EVT_MASK) maskS_r <= avs_writedata[7:0];
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence reqWaiting;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence tickEnabled;
        tickRollover && ctlS_r[7] && ctlS_r[5] && !wrDone;
    endsequence
    chk_req_answer: assert property (reqWaiting |=> done)
        else $error("bus request not answered");
    chk_wait_one: assert property (done |=> avs_waitrequest)
        else $error("waitrequest low too long");
    chk_pe1_top: assert property (done && avs_read && wordAddr == `IRQ_OFS_PERIPH_EN1
        |-> !avs_readdata[7]) else $error("enable bit 7 reads one");
    chk_global_gate: assert property (!ctlS_r[7] |=> !coreIrqReq)
        else $error("request with global enable off");
    chk_periph_req: assert property (ctlS_r[7] && ctlS_r[6] && !wrDone
        && |(pe1S_r & periphFlags) |=> coreIrqReq) else $error("peripheral request missing");
    chk_tick_core: assert property (tickEnabled |=> ##1 coreIrqReq)
        else $error("tick request missing");
    chk_tick_status: assert property (tickRollover && maskS_r[0] |=> irqOut)
        else $error("tick status not raised");
    chk_wake_status: assert property (lowPowerWakeup && maskS_r[2] |=> irqOut)
        else $error("wakeup status not raised");
    chk_irq_hold: assert property (irqOut && !avs_write && !$past(avs_write) |=> irqOut)
        else $error("interrupt dropped without a write");
    chk_irq_masked: assert property (maskS_r == 8'h00 && $past(maskS_r) == 8'h00 |-> !irqOut)
        else $error("interrupt while fully masked");
endmodule : interrupt_enable_flag_logic_checker

bind interrupt_enable_flag_logic interrupt_enable_flag_logic_checker
    i_interrupt_enable_flag_logic_checker (.clock, .rst_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .tickRollover, .externalIrqPin, .extEdgeRising, .portPinsA, .portPinsB,
    .lowPowerWakeup, .periphFlags, .coreIrqReq, .irqOut);

// ===== verification/tick_counter_model.sv
// Tick counter beside the interrupt block; pulses rollover on wrap.
// Assumes the bench loads it before running; its count has no reset.
module tick_counter_model (
    input  wire logic       clock,
    input  wire logic       tickLoad,
    input  wire logic [7:0] tickLoadVal,
    input  wire logic       tickRun,
    output logic            tickRollover
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] count_r;
    always_ff @(posedge clock) begin
        if (tickLoad) count_r <= tickLoadVal;
        else if (tickRun) count_r <= count_r + 8'h01;
    end
    assign tickRollover = tickRun && count_r == 8'hff;
endmodule : tick_counter_model

// ===== verification/test_interrupt_enable_flag_logic.sv
// Self-checking bench of the interrupt enable and flag block.
// Assumes the design, its checker and the tick counter model compile first.
`include "irq_enable_map.svh"
module test_interrupt_enable_flag_logic;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] CTL = `IRQ_OFS_CONTROL;
    localparam logic [4:0] PE1 = `IRQ_OFS_PERIPH_EN1;
    localparam logic [4:0] STS = `IRQ_OFS_EVT_STATUS;
    localparam logic [4:0] MSK = `IRQ_OFS_EVT_MASK;
    logic        clock, rst_n, avs_read, avs_write, avs_waitrequest;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0]  avs_byteenable;
    logic        tickRollover, externalIrqPin, extEdgeRising, lowPowerWakeup;
    logic        coreIrqReq, irqOut, tickLoad, tickRun;
    logic [7:0]  portPinsA, portPinsB, periphFlags, rdData;
    int          num_errors, checks_done;
    interrupt_enable_flag_logic i_interrupt_enable_flag_logic (.clock, .rst_n,
        .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .tickRollover, .externalIrqPin,
        .extEdgeRising, .portPinsA, .portPinsB, .lowPowerWakeup, .periphFlags,
        .coreIrqReq, .irqOut);
    tick_counter_model i_tick_counter_model (.clock, .tickLoad,
        .tickLoadVal(8'hfe), .tickRun, .tickRollover);
    always #12.5 clock = ~clock;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic bit1(input logic seen, input logic exp);
        check({7'h00, seen}, {7'h00, exp});
    endtask : bit1
    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask : idle
    task automatic xfer(input logic wr, input logic [4:0] a, input logic [7:0] d);
        @(posedge clock);
        avs_address   <= a;
        avs_writedata <= {24'h000000, d};
        avs_read      <= !wr;
        avs_write     <= wr;
        do begin
            @(posedge clock);
        end while (avs_waitrequest !== 1'b0);
        rdData = avs_readdata[7:0];
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [7:0] exp);
        xfer(1'b0, a, 8'h00);
        check(rdData, exp);
    endtask : rd
    task automatic fireTick();
        @(posedge clock);
        tickLoad <= 1'b1;
        @(posedge clock);
        tickLoad <= 1'b0;
        tickRun  <= 1'b1;
        idle(2);
        tickRun  <= 1'b0;
        idle(2);
    endtask : fireTick
    task automatic scnRegisters();
        rd(CTL, 8'h00);
        rd(PE1, 8'h00);
        wr(CTL, 8'hf8);
        rd(CTL, 8'hf8);
        wr(PE1, 8'hff);
        rd(PE1, 8'h7f);
        avs_byteenable <= 4'h0;
        wr(PE1, 8'h00);
        avs_byteenable <= 4'hf;
        rd(PE1, 8'h7f);
        wr(5'h18, 8'hff);
        rd(5'h18, 8'h00);
        wr(CTL, 8'h00);
        wr(PE1, 8'h00);
    endtask : scnRegisters
    task automatic scnTick();
        wr(MSK, 8'h01);
        fireTick();
        rd(CTL, 8'h04);
        bit1(irqOut, 1'b1);
        wr(CTL, 8'h24);
        idle(3);
        bit1(coreIrqReq, 1'b0);
        wr(CTL, 8'ha4);
        idle(3);
        bit1(coreIrqReq, 1'b1);
        rd(STS, 8'h09);
        idle(20);
        rd(CTL, 8'ha4);
        wr(CTL, 8'ha0);
        wr(STS, 8'h0f);
        bit1(coreIrqReq, 1'b0);
        idle(1);
        bit1(irqOut, 1'b0);
        fireTick();
        idle(1);
        bit1(coreIrqReq, 1'b1);
        wr(CTL, 8'h84);
        idle(3);
        bit1(coreIrqReq, 1'b0);
        wr(CTL, 8'h00);
        wr(STS, 8'h0f);
    endtask : scnTick
    task automatic scnPins();
        @(posedge clock);
        externalIrqPin <= 1'b1;
        idle(6);
        rd(CTL, 8'h02);
        wr(CTL, 8'h00);
        externalIrqPin <= 1'b0;
        idle(6);
        rd(CTL, 8'h00);
        extEdgeRising  <= 1'b0;
        externalIrqPin <= 1'b1;
        idle(6);
        rd(CTL, 8'h00);
        externalIrqPin <= 1'b0;
        idle(6);
        rd(CTL, 8'h02);
        wr(CTL, 8'h00);
        extEdgeRising <= 1'b1;
        wr(`IRQ_OFS_PIN_EN_A, 8'h01);
        portPinsA <= 8'h02;
        idle(6);
        rd(CTL, 8'h00);
        portPinsA <= 8'h03;
        idle(6);
        rd(CTL, 8'h01);
        wr(CTL, 8'h00);
        wr(`IRQ_OFS_PIN_EN_B, 8'h80);
        portPinsB <= 8'h80;
        idle(6);
        rd(CTL, 8'h01);
        wr(CTL, 8'h00);
        wr(MSK, 8'h04);
        lowPowerWakeup <= 1'b1;
        @(posedge clock);
        lowPowerWakeup <= 1'b0;
        idle(2);
        bit1(irqOut, 1'b1);
        rd(CTL, 8'h01);
        wr(CTL, 8'h89);
        idle(3);
        bit1(coreIrqReq, 1'b1);
        wr(CTL, 8'h93);
        idle(3);
        bit1(coreIrqReq, 1'b1);
        wr(CTL, 8'h82);
        idle(3);
        bit1(coreIrqReq, 1'b0);
        wr(CTL, 8'h00);
        wr(STS, 8'h0f);
        rd(STS, 8'h00);
    endtask : scnPins
    task automatic scnPeriph();
        wr(CTL, 8'h80);
        wr(PE1, 8'h7f);
        periphFlags <= 8'h01;
        idle(3);
        bit1(coreIrqReq, 1'b0);
        wr(CTL, 8'hc0);
        for (int i = 0; i < 7; i++) begin
            periphFlags <= 8'h01 << i;
            idle(3);
            bit1(coreIrqReq, 1'b1);
            wr(PE1, 8'h7f ^ (8'h01 << i));
            idle(3);
            bit1(coreIrqReq, 1'b0);
            wr(PE1, 8'h7f);
        end
        wr(CTL, 8'h40);
        idle(3);
        bit1(coreIrqReq, 1'b0);
        wr(CTL, 8'hc0);
        wr(PE1, 8'hff);
        periphFlags <= 8'h80;
        idle(3);
        bit1(coreIrqReq, 1'b0);
        periphFlags <= 8'h00;
        wr(CTL, 8'h00);
    endtask : scnPeriph
    task automatic scnReset();
        wr(CTL, 8'hf8);
        wr(MSK, 8'h01);
        fireTick();
        bit1(irqOut, 1'b1);
        bit1(coreIrqReq, 1'b1);
        externalIrqPin <= 1'b1;
        rst_n <= 1'b0;
        idle(2);
        bit1(coreIrqReq, 1'b0);
        bit1(irqOut, 1'b0);
        bit1(avs_waitrequest, 1'b1);
        rst_n <= 1'b1;
        idle(4);
        rd(CTL, 8'h00);
        rd(PE1, 8'h00);
        rd(MSK, 8'h00);
    endtask : scnReset
    task automatic wrap_up();
        $display("Checks done: %0d, errors: %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up
    initial begin
        clock = 1'b0;
        rst_n = 1'b0;
        {avs_read, avs_write, tickLoad, tickRun, externalIrqPin, lowPowerWakeup} = '0;
        {avs_address, avs_writedata, portPinsA, portPinsB, periphFlags} = '0;
        avs_byteenable = 4'hf;
        extEdgeRising = 1'b1;
        num_errors = 0;
        checks_done = 0;
        idle(10);
        rst_n <= 1'b1;
        idle(4);
        scnRegisters();
        scnTick();
        scnPins();
        scnPeriph();
        scnReset();
        wrap_up();
    end
    initial begin
        #(25 * 20000);
        num_errors++;
        wrap_up();
    end
endmodule : test_interrupt_enable_flag_logic
